// >>> pkg/stdc_pkg.sv
// Overview of operation
// - 24-bit down counter that wraps at zero
// - Any current-value write clears counter
// - Enabled: decrement by one each clock
// - Cycle after zero reloads, then decrements
// - Wrap flag sets when a decrement brings count from one to zero (not on a clear)
// - Reading status clears the wrap flag
// - Counter value after reset is undefined
// - Zero reload keeps counter parked at zero
package stdc_pkg;
  localparam int CNT_W  = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] RELOAD_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] CURR_OFS   = 4'h8;
  // Control/status field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_WRAP_BIT = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 24'h000001;
  localparam logic [CNT_W-1:0] RELOAD_RST = 24'h000000;
endpackage

// >>> hdl/stdc_counter_core.sv
module stdc_counter_core (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Control
  input  wire logic                        enable,
  input  wire logic                        clearCount,
  input  wire logic [stdc_pkg::CNT_W-1:0]  reloadValue,
  // State
  output logic      [stdc_pkg::CNT_W-1:0]  count,
  output logic                             wrapEvent
);
  logic [stdc_pkg::CNT_W-1:0] count_ff;
  logic [stdc_pkg::CNT_W-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (clearCount) begin
      nxt_count = stdc_pkg::CNT_ZERO;
    end else if (enable) begin
      if (count_ff == stdc_pkg::CNT_ZERO) begin
        nxt_count = reloadValue;
      end else begin
        nxt_count = count_ff - stdc_pkg::CNT_ONE;
      end
    end
  end

  // Software may not rely on it, but a known count keeps the checks free of unknowns
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_ff <= stdc_pkg::CNT_ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count     = count_ff;
  // Transition into zero while counting, never on a clear
  assign wrapEvent = enable && !clearCount && (count_ff == stdc_pkg::CNT_ONE);

  hold_disabled_a: assert property (@(posedge mclk) disable iff (rst)
    (!enable && !clearCount) |=> (count_ff == $past(count_ff)))
    else $error("count moved while disabled");
  clear_write_a: assert property (@(posedge mclk) disable iff (rst)
    clearCount |=> (count_ff == stdc_pkg::CNT_ZERO))
    else $error("write did not clear count");
  decrement_step_a: assert property (@(posedge mclk) disable iff (rst)
    (enable && !clearCount && count_ff != stdc_pkg::CNT_ZERO)
      |=> (count_ff == $past(count_ff) - stdc_pkg::CNT_ONE))
    else $error("count did not decrement");
  reload_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (enable && !clearCount && count_ff == stdc_pkg::CNT_ZERO) |=> (count_ff == $past(reloadValue)))
    else $error("no reload after zero");
endmodule

// >>> hdl/stdc_tick_timer.sv
module stdc_tick_timer (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [stdc_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [stdc_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [stdc_pkg::DATA_W-1:0]  regRdata,
  // Status
  output logic                              tickWrapFlag
);
  logic                        enable_ff;
  logic [stdc_pkg::CNT_W-1:0]  tickReloadValue_ff;
  logic                        tickWrapFlag_ff;
  logic [stdc_pkg::DATA_W-1:0] regRdata_ff;
  logic [stdc_pkg::DATA_W-1:0] nxt_rdata;
  logic [stdc_pkg::CNT_W-1:0]  tickCurrentValue;
  logic                        wrapEvent;
  logic                        clearCount;

  assign clearCount = regWr && (regAddr == stdc_pkg::CURR_OFS);

  stdc_counter_core u_core (
    .mclk        (mclk),
    .rst         (rst),
    .enable      (enable_ff),
    .clearCount  (clearCount),
    .reloadValue (tickReloadValue_ff),
    .count       (tickCurrentValue),
    .wrapEvent   (wrapEvent)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_ff <= 1'b0;
    end else if (regWr && regAddr == stdc_pkg::CTRL_OFS) begin
      enable_ff <= regWdata[stdc_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tickReloadValue_ff <= stdc_pkg::RELOAD_RST;
    end else if (regWr && regAddr == stdc_pkg::RELOAD_OFS) begin
      tickReloadValue_ff <= regWdata[stdc_pkg::CNT_W-1:0];
    end
  end

  // Set beats the read-clear so a wrap in the read cycle is kept
  always_ff @(posedge mclk) begin
    if (rst) begin
      tickWrapFlag_ff <= 1'b0;
    end else if (wrapEvent) begin
      tickWrapFlag_ff <= 1'b1;
    end else if (regRd && regAddr == stdc_pkg::CTRL_OFS) begin
      tickWrapFlag_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (regRd) begin
      unique case (regAddr)
        stdc_pkg::CTRL_OFS: begin
          nxt_rdata[stdc_pkg::CTRL_EN_BIT]   = enable_ff;
          nxt_rdata[stdc_pkg::CTRL_WRAP_BIT] = tickWrapFlag_ff;
        end
        stdc_pkg::RELOAD_OFS: nxt_rdata[stdc_pkg::CNT_W-1:0] = tickReloadValue_ff;
        stdc_pkg::CURR_OFS:   nxt_rdata[stdc_pkg::CNT_W-1:0] = tickCurrentValue;
        default:              nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata_ff <= '0;
    end else begin
      regRdata_ff <= nxt_rdata;
    end
  end

  assign regRdata     = regRdata_ff;
  assign tickWrapFlag = tickWrapFlag_ff;

  flag_set_a: assert property (@(posedge mclk) disable iff (rst)
    wrapEvent |=> tickWrapFlag_ff)
    else $error("wrap flag not set");
  flag_readclr_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == stdc_pkg::CTRL_OFS && !wrapEvent) |=> !tickWrapFlag_ff)
    else $error("read did not clear flag");
  no_flag_off_a: assert property (@(posedge mclk) disable iff (rst)
    (!enable_ff && !tickWrapFlag_ff && !$past(wrapEvent)) |=> !tickWrapFlag_ff)
    else $error("flag set while disabled");
  zero_park_a: assert property (@(posedge mclk) disable iff (rst)
    (enable_ff && tickReloadValue_ff == stdc_pkg::CNT_ZERO && tickCurrentValue == stdc_pkg::CNT_ZERO
      && !regWr) |=> (tickCurrentValue == stdc_pkg::CNT_ZERO))
    else $error("count left zero with zero reload");

  // Read port
  rd_idle_zero_a: assert property (@(posedge mclk) disable iff (rst)
    !regRd
      |=> (regRdata_ff == '0))
    else $error("read data not zero when idle");

  rd_enable_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == stdc_pkg::CTRL_OFS)
      |=> (regRdata_ff[stdc_pkg::CTRL_EN_BIT] == $past(enable_ff)))
    else $error("enable bit read wrong");

  rd_wrap_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == stdc_pkg::CTRL_OFS)
      |=> (regRdata_ff[stdc_pkg::CTRL_WRAP_BIT] == $past(tickWrapFlag_ff)))
    else $error("wrap bit read wrong");

  rd_reload_val_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == stdc_pkg::RELOAD_OFS)
      |=> (regRdata_ff[stdc_pkg::CNT_W-1:0] == $past(tickReloadValue_ff)))
    else $error("reload value read wrong");

  rd_current_val_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr == stdc_pkg::CURR_OFS)
      |=> (regRdata_ff[stdc_pkg::CNT_W-1:0] == $past(tickCurrentValue)))
    else $error("current value read wrong");

  rd_upper_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr != stdc_pkg::CTRL_OFS)
      |=> (regRdata_ff[stdc_pkg::DATA_W-1:stdc_pkg::CNT_W] == '0))
    else $error("bits above the count not zero");

  rd_unmapped_a: assert property (@(posedge mclk) disable iff (rst)
    (regRd && regAddr != stdc_pkg::CTRL_OFS && regAddr != stdc_pkg::RELOAD_OFS && regAddr != stdc_pkg::CURR_OFS)
      |=> (regRdata_ff == '0))
    else $error("unmapped read not zero");

  // Control and reload registers
  en_write_a: assert property (@(posedge mclk) disable iff (rst)
    (regWr && regAddr == stdc_pkg::CTRL_OFS)
      |=> (enable_ff == $past(regWdata[stdc_pkg::CTRL_EN_BIT])))
    else $error("enable write lost");

  en_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(regWr && regAddr == stdc_pkg::CTRL_OFS)
      |=> $stable(enable_ff))
    else $error("enable changed without write");

  reload_write_a: assert property (@(posedge mclk) disable iff (rst)
    (regWr && regAddr == stdc_pkg::RELOAD_OFS)
      |=> (tickReloadValue_ff == $past(regWdata[stdc_pkg::CNT_W-1:0])))
    else $error("reload write lost");

  reload_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(regWr && regAddr == stdc_pkg::RELOAD_OFS)
      |=> $stable(tickReloadValue_ff))
    else $error("reload changed without write");

  reset_state_a: assert property (@(posedge mclk)
    rst
      |=> (!enable_ff && !tickWrapFlag_ff && regRdata_ff == '0 && tickReloadValue_ff == stdc_pkg::RELOAD_RST))
    else $error("state not cleared by reset");

  // Wrap flag
  flag_sticky_a: assert property (@(posedge mclk) disable iff (rst)
    (tickWrapFlag_ff && !(regRd && regAddr == stdc_pkg::CTRL_OFS))
      |=> tickWrapFlag_ff)
    else $error("flag dropped without status read");

  flag_cause_a: assert property (@(posedge mclk) disable iff (rst)
    (!tickWrapFlag_ff && !wrapEvent)
      |=> !tickWrapFlag_ff)
    else $error("flag set without wrap");

  flag_set_read_a: assert property (@(posedge mclk) disable iff (rst)
    (wrapEvent && regRd && regAddr == stdc_pkg::CTRL_OFS)
      |=> tickWrapFlag_ff)
    else $error("read clear beat a wrap");

  wrap_to_zero_a: assert property (@(posedge mclk) disable iff (rst)
    wrapEvent
      |=> (tickCurrentValue == stdc_pkg::CNT_ZERO))
    else $error("wrap without reaching zero");

  wrap_once_a: assert property (@(posedge mclk) disable iff (rst)
    wrapEvent
      |=> !wrapEvent)
    else $error("wrap seen twice in a row");

  off_no_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    !enable_ff
      |-> !wrapEvent)
    else $error("wrap while disabled");

  zero_no_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    (tickReloadValue_ff == stdc_pkg::CNT_ZERO && tickCurrentValue == stdc_pkg::CNT_ZERO)
      |-> !wrapEvent)
    else $error("wrap with count parked at zero");

  // Counting
  clear_no_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    clearCount
      |-> !wrapEvent)
    else $error("wrap on a current-value write");

  clear_after_a: assert property (@(posedge mclk) disable iff (rst)
    clearCount
      |=> !wrapEvent)
    else $error("wrap right after a clear");

  count_from_one_a: assert property (@(posedge mclk) disable iff (rst)
    (enable_ff && !clearCount && tickCurrentValue == stdc_pkg::CNT_ONE)
      |=> (tickCurrentValue == stdc_pkg::CNT_ZERO))
    else $error("count did not reach zero from one");

  clear_reload_a: assert property (@(posedge mclk) disable iff (rst)
    (clearCount ##1 (enable_ff && !regWr))
      |=> (tickCurrentValue == $past(tickReloadValue_ff)))
    else $error("no reload after a clear");
endmodule

// >>> dv/stdc_tick_timer_tb.sv
module stdc_tick_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  regAddr  = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic [31:0] regRdata;
  logic        tickWrapFlag;
  logic [31:0] a;
  logic [31:0] b;
  int          fails    = 0;
  int          n_checks = 0;
  int          cycles   = 0;
  stdc_tick_timer stdc_tick_timer_inst (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tickWrapFlag(tickWrapFlag));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Ceiling well above the roughly 130 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= ad;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask
  // Data is registered at the strobe edge and stands only in the next cycle
  task automatic rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= ad;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, a); chk(a, 32'h0);
    rd(4'h4, a); chk(a, 32'h0);
    wr(4'hC, 32'h1234); rd(4'hC, a); chk(a, 32'h0);
    $display("test reset_map done");
    wr(4'h4, 32'hFFFFFFFF); rd(4'h4, a); chk(a, 32'h00FFFFFF);
    wr(4'h8, 32'hABCDEF); rd(4'h8, a); chk(a, 32'h0);
    wr(4'h0, 32'h1); waitc(4); rd(4'h8, a);
    chk(a & 32'hFF000000, 32'h0);
    chk({31'h0, a[23:0] > 24'hFFFF00}, 32'h1);
    rd(4'h8, a); rd(4'h8, b); chk(a - b, 32'h2);
    $display("test count_down done");
    wr(4'h0, 32'h0); rd(4'h8, a); waitc(20); rd(4'h8, b); chk(b, a);
    rd(4'h0, a); chk(a, 32'h0);
    $display("test hold done");
    wr(4'h4, 32'h3); wr(4'h8, 32'h0); wr(4'h0, 32'h1); waitc(20);
    chk({31'h0, tickWrapFlag}, 32'h1);
    rd(4'h0, a); chk(a & 32'h00010000, 32'h00010000);
    wr(4'h0, 32'h0); waitc(2); rd(4'h0, a); rd(4'h0, a); chk(a, 32'h0);
    chk({31'h0, tickWrapFlag}, 32'h0);
    $display("test wrap_flag done");
    wr(4'h4, 32'h0); wr(4'h8, 32'h0); wr(4'h0, 32'h1); waitc(10);
    rd(4'h8, a); chk(a, 32'h0);
    rd(4'h0, a); chk(a, 32'h1);
    $display("test zero_reload done");
    summarize();
  end
endmodule
